// File: design/fci_defs.svh
// Register offset, field positions, command codes and unlock addresses
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH
`define FCI_STATUS_OFFSET   12'h7c0
`define FCI_BIT_IRQ_ENABLE  7
`define FCI_BIT_IRQ_FLAG    6
`define FCI_BIT_PROG_MODE   5
`define FCI_BIT_IDLE        4
`define FCI_BIT_ZERO        0
`define FCI_RESERVED_READ   3'h0
`define FCI_ARRAY_BYTES     254*1024
`define FCI_ADDR_W          18
`define FCI_CMD_UNLOCK1     16'haaaa
`define FCI_CMD_UNLOCK2     16'h5555
`define FCI_CMD_RESET       16'hf0f0
`define FCI_CMD_PROGRAM     16'ha0a0
`define FCI_CMD_ERASE_SETUP 16'h8080
`define FCI_CMD_CHIP_ERASE  16'h1010
`define FCI_CMD_SECT_ERASE  16'h3030
`define FCI_UNLOCK_ADDR1    18'h15556
`define FCI_UNLOCK_ADDR2    18'h2aaaa
`endif

// File: design/fci_pkg.sv
// Types shared by the flash CPU interface files
package fci_pkg;
  typedef enum logic [1:0] {
    FCI_OP_NONE    = 2'h0,
    FCI_OP_PROGRAM = 2'h1,
    FCI_OP_CHIP    = 2'h2,
    FCI_OP_SECTOR  = 2'h3
  } fci_op_t;

  typedef struct packed {
    fci_op_t     op;
    logic [17:0] addr;
    logic [15:0] data;
  } fci_cmd_t;

  typedef enum logic [2:0] {
    FCI_SEQ_READ = 3'b000,
    FCI_SEQ_UL1  = 3'b001,
    FCI_SEQ_UL2  = 3'b011,
    FCI_SEQ_SET  = 3'b010,
    FCI_SEQ_EUL1 = 3'b110,
    FCI_SEQ_EUL2 = 3'b111
  } fci_seq_t;
endpackage

// File: design/fci_edge_detect.sv
// Rising edge pulse from a registered level
`timescale 1ns/1ps
module fci_edge_detect (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);
  logic level_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Idle level, so leaving reset gives no false edge
      level_q <= 1'b1;
    end else begin
      level_q <= level;
    end
  end

  assign rise = level & ~level_q;
endmodule

// File: design/fci_cmd_decoder.sv
// Half-word command sequence decoder
`timescale 1ns/1ps
`include "fci_defs.svh"
module fci_cmd_decoder
  import fci_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Accepted half-word writes
  input  wire logic        wr,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] data,
  // Decoded operation, one-cycle pulse
  output logic             start,
  output fci_cmd_t         cmd
);
  fci_seq_t seq;
  fci_seq_t next_seq;
  logic     pending_program;
  logic     next_start;
  fci_cmd_t next_cmd;

  always_comb begin
    next_seq   = seq;
    next_start = 1'b0;
    next_cmd   = '{op: FCI_OP_NONE, addr: addr, data: data};
    if (wr) begin
      next_seq = FCI_SEQ_READ;
      if (data == `FCI_CMD_RESET) begin
        next_seq = FCI_SEQ_READ;
      end else begin
        unique case (seq)
          FCI_SEQ_READ: begin
            if (addr == `FCI_UNLOCK_ADDR1 && data == `FCI_CMD_UNLOCK1) next_seq = FCI_SEQ_UL1;
          end
          FCI_SEQ_UL1: begin
            if (addr == `FCI_UNLOCK_ADDR2 && data == `FCI_CMD_UNLOCK2) next_seq = FCI_SEQ_UL2;
          end
          FCI_SEQ_UL2: begin
            if (addr == `FCI_UNLOCK_ADDR1 && data == `FCI_CMD_PROGRAM) next_seq = FCI_SEQ_SET;
            if (addr == `FCI_UNLOCK_ADDR1 && data == `FCI_CMD_ERASE_SETUP) next_seq = FCI_SEQ_SET;
          end
          FCI_SEQ_SET: begin
            if (pending_program) begin
              next_start = 1'b1;
              next_cmd.op = FCI_OP_PROGRAM;
            end else if (addr == `FCI_UNLOCK_ADDR1 && data == `FCI_CMD_UNLOCK1) begin
              next_seq = FCI_SEQ_EUL1;
            end
          end
          FCI_SEQ_EUL1: begin
            if (addr == `FCI_UNLOCK_ADDR2 && data == `FCI_CMD_UNLOCK2) next_seq = FCI_SEQ_EUL2;
          end
          FCI_SEQ_EUL2: begin
            if (addr == `FCI_UNLOCK_ADDR1 && data == `FCI_CMD_CHIP_ERASE) begin
              next_start = 1'b1;
              next_cmd.op = FCI_OP_CHIP;
            end else if (data == `FCI_CMD_SECT_ERASE) begin
              next_start = 1'b1;
              next_cmd.op = FCI_OP_SECTOR;
            end
          end
          default: next_seq = FCI_SEQ_READ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq             <= FCI_SEQ_READ;
      pending_program <= 1'b0;
    end else begin
      seq <= next_seq;
      if (wr && seq == FCI_SEQ_UL2) begin
        pending_program <= (data == `FCI_CMD_PROGRAM);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      start <= 1'b0;
      cmd   <= '{op: FCI_OP_NONE, addr: 18'h0, data: 16'h0};
    end else begin
      start <= next_start;
      cmd   <= next_cmd;
    end
  end
endmodule

// File: design/fci_flash_interface.sv
// CPU interface and status register of the on-chip flash array
//
// Summary of operation
// - Array of 254 KiB; whole erase, sector erase, half-word program.
// - ROM mode reads deliver a full 32-bit word.
// - Idle bit of status register mirrors the algorithm idle line.
// - While busy, new commands are refused and array data is withheld.
// - Busy reads return sequence status flags instead of data.
// - Rising edge of idle line sets the completion flag.
// - Interrupt request is enable AND flag.
// - Writing 0 clears the flag; writing 1 leaves it.
// - Program mode off: writes ignored, reads are 32-bit.
// - Program mode on: writes accepted, only 16-bit reads.
// - Program mode bit is frozen while the algorithm is busy.
// - Interrupt enable is read/write, resets to 0.
// - Flag resets to 0 and reads back its state.
// - Bits 3 to 1 are reserved and ignore writes.
// - Bit 0 reads 0 and resets to 0.
// - Only the CPU bus reaches the status register.
// - Programmer mode routes pins out and halts CPU.
// - Invalid or out-of-sequence command returns the array to read mode.
// - Reset leaves ROM mode with program mode bit at 0.
`timescale 1ns/1ps
`include "fci_defs.svh"
module fci_flash_interface
  import fci_pkg::*;
#(
  parameter int ADDR_W = `FCI_ADDR_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // CPU register access
  input  wire logic              reg_sel,
  input  wire logic [11:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // CPU flash area access
  input  wire logic              mem_sel,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_wr,
  input  wire logic              mem_rd,
  input  wire logic              mem_word,
  input  wire logic [15:0]       mem_wdata,
  output logic      [31:0]       mem_rdata,
  output logic                   mem_ack,
  output logic                   mem_err,
  // Flash macro side
  input  wire logic              algorithm_idle_line,
  input  wire logic [31:0]       array_rdata,
  input  wire logic [7:0]        seq_status,
  output logic      [ADDR_W-1:0] array_addr,
  output logic                   array_rd,
  output logic                   cmd_start,
  output fci_cmd_t               cmd_out,
  // Programmer pin mode
  input  wire logic              programmer_mode_pin,
  output logic                   cpu_halt,
  output logic                   pins_to_flash,
  // Interrupt to the CPU
  output logic                   done_irq
);
  //////////////////////////////////////////////////////////////////////////////
  logic idle_s1;
  logic idle_s2;
  logic prog_s1;
  logic prog_s2;
  logic idle_rise;
  logic done_irq_enable;
  logic done_irq_flag;
  logic prog_mode;
  logic reg_hit;
  logic reg_write;
  logic dec_wr;
  logic dec_start;
  fci_cmd_t dec_cmd;
  // Request stage of a flash access, answered one edge later
  logic     acc_q;
  logic     rd_q;
  logic     word_q;
  logic     busy_q;
  logic     rom_q;
  logic     low_half_q;

  // Synchronisers for the macro level and the mode pin
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Idle level, so the edge detector sees no false rise
      idle_s1 <= 1'b1;
      idle_s2 <= 1'b1;
      prog_s1 <= 1'b0;
      prog_s2 <= 1'b0;
    end else begin
      idle_s1 <= algorithm_idle_line;
      idle_s2 <= idle_s1;
      prog_s1 <= programmer_mode_pin;
      prog_s2 <= prog_s1;
    end
  end

  fci_edge_detect u_idle_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .level   (idle_s2),
    .rise    (idle_rise)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Status/control register, CPU bus only; pins never decode it
  assign reg_hit   = reg_sel && reg_addr == `FCI_STATUS_OFFSET && !prog_s2;
  assign reg_write = reg_hit && reg_wr;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_irq_enable <= 1'b0;
    end else if (reg_write) begin
      done_irq_enable <= reg_wdata[`FCI_BIT_IRQ_ENABLE];
    end
  end

  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_irq_flag <= 1'b0;
    end else if (idle_rise) begin
      done_irq_flag <= 1'b1;
    end else if (reg_write && !reg_wdata[`FCI_BIT_IRQ_FLAG]) begin
      done_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prog_mode <= 1'b0;
    end else if (reg_write && idle_s2) begin
      prog_mode <= reg_wdata[`FCI_BIT_PROG_MODE];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_hit && reg_rd) begin
      reg_rdata <= {done_irq_enable, done_irq_flag, prog_mode,
                    idle_s2,
                    `FCI_RESERVED_READ,
                    1'b0};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_irq <= 1'b0;
    end else begin
      done_irq <= done_irq_enable & done_irq_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash area access
  assign dec_wr = mem_sel && mem_wr && prog_mode && idle_s2 && !prog_s2;

  fci_cmd_decoder u_decoder (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr      (dec_wr),
    .addr    (mem_addr),
    .data    (mem_wdata),
    .start   (dec_start),
    .cmd     (dec_cmd)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_start <= 1'b0;
      cmd_out   <= '{op: FCI_OP_NONE, addr: 18'h0, data: 16'h0};
    end else begin
      cmd_start <= dec_start;
      cmd_out   <= dec_cmd;
    end
  end

  // Address goes to the macro first; its data is taken on the next edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      array_addr <= '0;
      array_rd   <= 1'b0;
      acc_q      <= 1'b0;
      rd_q       <= 1'b0;
      word_q     <= 1'b0;
      busy_q     <= 1'b0;
      rom_q      <= 1'b0;
      low_half_q <= 1'b0;
    end else begin
      array_addr <= mem_addr;
      array_rd   <= mem_sel && mem_rd && idle_s2 && !prog_s2;
      acc_q      <= mem_sel && (mem_rd || mem_wr) && !prog_s2;
      rd_q       <= mem_sel && mem_rd && !prog_s2;
      word_q     <= mem_word;
      busy_q     <= !idle_s2;
      rom_q      <= !prog_mode;
      low_half_q <= mem_addr[1];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mem_rdata <= 32'h0;
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
    end else begin
      mem_ack   <= acc_q;
      mem_err   <= 1'b0;
      mem_rdata <= 32'h0;
      if (rd_q) begin
        if (busy_q) begin
          mem_rdata <= {24'h0, seq_status};
        end else if (rom_q) begin
          mem_rdata <= array_rdata;
        end else if (word_q) begin
          mem_err <= 1'b1;
        end else begin
          mem_rdata <= {16'h0, low_half_q ? array_rdata[15:0] : array_rdata[31:16]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpu_halt      <= 1'b0;
      pins_to_flash <= 1'b0;
    end else begin
      cpu_halt      <= prog_s2;
      pins_to_flash <= prog_s2;
    end
  end
endmodule

// File: dv/fci_macro_model.sv
// Flash macro model: busy timer and array read pattern
`timescale 1ns/1ps
module fci_macro_model #(
  parameter int BUSY_CYC = 30
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Interface side
  input  wire logic [17:0] array_addr,
  input  wire logic        cmd_start,
  output logic             idle,
  output logic      [31:0] array_rdata,
  output logic      [7:0]  seq_status
);
  logic [7:0] busy_cnt;
  assign idle = busy_cnt == 8'h00;
  assign seq_status = 8'h48;
  // Stored words turn to garbage while busy
  assign array_rdata = {array_addr[17:2] ^ 16'h5a5a, array_addr[17:2]} ^ {32{!idle}};
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_cnt <= 8'h00;
    end else if (cmd_start) begin
      busy_cnt <= BUSY_CYC[7:0];
    end else if (busy_cnt != 8'h00) begin
      busy_cnt <= busy_cnt - 8'h01;
    end
  end
endmodule

// File: dv/fci_flash_interface_sva.sv
// Port checker for the flash CPU interface
`timescale 1ns/1ps
module fci_flash_interface_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // Register and flash access
  input wire logic        reg_sel,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        mem_sel,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic        mem_word,
  input wire logic        mem_ack,
  input wire logic        mem_err,
  // Macro, pins and interrupt
  input wire logic        algorithm_idle_line,
  input wire logic        programmer_mode_pin,
  input wire logic        cmd_start,
  input wire logic        array_rd,
  input wire logic        cpu_halt,
  input wire logic        pins_to_flash,
  input wire logic        done_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic wr_hit;
  logic clr_hit;
  assign wr_hit = reg_sel && reg_wr && reg_addr == 12'h7c0;
  assign clr_hit = wr_hit && !(reg_wdata[7] && reg_wdata[6]);
  //////////////////////////////////////////////////////////////////
  property p_irq_rise;
    $rose(done_irq) |-> $past(wr_hit) || $past(wr_hit, 2) || $past(algorithm_idle_line, 4);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(done_irq) |-> $past(clr_hit) || $past(clr_hit, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
  property p_ack;
    mem_sel && (mem_rd || mem_wr) && !programmer_mode_pin && !cpu_halt |-> ##2 mem_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("flash access not acked");
  property p_halt_noack;
    programmer_mode_pin && cpu_halt && $past(cpu_halt) |-> !mem_ack;
  endproperty
  a_halt_noack: assert property (p_halt_noack) else $error("ack while halted");
  property p_halt_rise;
    $rose(cpu_halt) |-> $past(programmer_mode_pin, 2) && pins_to_flash;
  endproperty
  a_halt_rise: assert property (p_halt_rise) else $error("halt without pin");
  property p_err;
    mem_err |-> $past(mem_sel && mem_rd && mem_word, 2);
  endproperty
  a_err: assert property (p_err) else $error("error without word read");
  property p_rdata_idle;
    !$past(reg_sel && reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_cmd;
    cmd_start |-> !$past(cmd_start) && $past(algorithm_idle_line, 4)
      && ($past(mem_sel && mem_wr, 2) || $past(mem_sel && mem_wr, 3));
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command start");
  property p_array_rd;
    array_rd |-> $past(mem_sel && mem_rd) && $past(algorithm_idle_line, 3);
  endproperty
  a_array_rd: assert property (p_array_rd) else $error("array read while busy");
endmodule
bind fci_flash_interface fci_flash_interface_sva fci_flash_interface_sva_i (.sys_clk, .reset,
  .reg_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mem_sel, .mem_wr, .mem_rd,
  .mem_word, .mem_ack, .mem_err, .algorithm_idle_line, .programmer_mode_pin, .cmd_start, .array_rd,
  .cpu_halt, .pins_to_flash, .done_irq);

// File: dv/fci_flash_interface_tb_top.sv
// Testbench for the flash CPU interface
`timescale 1ns/1ps
`include "fci_defs.svh"
module fci_flash_interface_tb_top;
  import fci_pkg::*;
  localparam logic [11:0] RA = `FCI_STATUS_OFFSET;
  localparam fci_op_t     OPS [3] = '{FCI_OP_PROGRAM, FCI_OP_CHIP, FCI_OP_SECTOR};
  localparam logic [15:0] DAT [3] = '{16'h1234, `FCI_CMD_CHIP_ERASE, `FCI_CMD_SECT_ERASE};
  logic        sys_clk, reset, reg_sel, reg_wr, reg_rd, mem_sel, mem_wr, mem_rd, mem_word;
  logic        prog_pin, idle, cmd_start, mem_ack, mem_err, cpu_halt, pins_to_flash, done_irq;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, seq_status, q;
  logic [17:0] mem_addr, array_addr;
  logic [15:0] mem_wdata;
  logic [31:0] mem_rdata, array_rdata;
  fci_cmd_t    cmd_out, last_cmd;
  int          errors, checked, starts;
  fci_flash_interface fci_flash_interface_i (.sys_clk, .reset, .reg_sel, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .mem_sel, .mem_addr, .mem_wr, .mem_rd, .mem_word,
    .mem_wdata, .mem_rdata, .mem_ack, .mem_err, .algorithm_idle_line(idle), .array_rdata,
    .seq_status, .array_addr, .array_rd(), .cmd_start, .cmd_out,
    .programmer_mode_pin(prog_pin), .cpu_halt, .pins_to_flash, .done_irq);
  fci_macro_model fci_macro_model_i (.sys_clk, .reset, .array_addr, .cmd_start, .idle,
    .array_rdata, .seq_status);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cmd_start === 1'b1) begin
      starts++;
      last_cmd = cmd_out;
    end
  end
  //////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, wr, !wr, a, d};
    @(posedge sys_clk);
    #1 {reg_sel, reg_wr, reg_rd} = 3'h0;
    q = reg_rdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string m);
    reg_acc(1'b0, a, 8'h00);
    cmp({24'h0, q}, {24'h0, e}, m);
  endtask
  task automatic mem_acc(input logic wr, input logic w, input logic [17:0] a,
                         input logic [15:0] d);
    @(posedge sys_clk);
    #1 {mem_sel, mem_wr, mem_rd, mem_word, mem_addr, mem_wdata} = {1'b1, wr, !wr, w, a, d};
    @(posedge sys_clk);
    #1 {mem_sel, mem_wr, mem_rd} = 3'h0;
    // Answer stands after the second edge
    @(posedge sys_clk);
    #1;
  endtask
  task automatic unlock(input logic [15:0] c);
    mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR1, `FCI_CMD_UNLOCK1);
    mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR2, `FCI_CMD_UNLOCK2);
    mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR1, c);
  endtask
  task automatic issue(input fci_op_t op);
    if (op == FCI_OP_PROGRAM) begin
      unlock(`FCI_CMD_PROGRAM);
      mem_acc(1'b1, 1'b0, 18'h00100, 16'h1234);
    end else begin
      unlock(`FCI_CMD_ERASE_SETUP);
      mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR1, `FCI_CMD_UNLOCK1);
      mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR2, `FCI_CMD_UNLOCK2);
      if (op == FCI_OP_CHIP) mem_acc(1'b1, 1'b0, `FCI_UNLOCK_ADDR1, `FCI_CMD_CHIP_ERASE);
      else mem_acc(1'b1, 1'b0, 18'h20000, `FCI_CMD_SECT_ERASE);
    end
  endtask
  task automatic wait_idle(input logic lvl);
    for (int n = 0; n < 200 && idle !== lvl; n++) @(posedge sys_clk);
    cmp({31'h0, idle}, {31'h0, lvl}, "idle wait");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    {reset, reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 23'h0};
    {mem_sel, mem_wr, mem_rd, mem_word, mem_addr, mem_wdata, prog_pin} = 39'h0;
    {errors, checked, starts} = 0;
    repeat (20) @(posedge sys_clk);
    #1 reset = 0;
    repeat (3) @(posedge sys_clk);
    rchk(RA, 8'h10, "reset value");
    rchk(12'h7c4, 8'h00, "unmapped");
    mem_acc(1'b0, 1'b1, 18'h00400, 16'h0000);
    cmp(mem_rdata, 32'h5b5a0100, "rom word");
    issue(FCI_OP_PROGRAM);
    $display("test rom_mode done");
    reg_acc(1'b1, RA, 8'h20);
    rchk(RA, 8'h30, "program mode");
    mem_acc(1'b0, 1'b0, 18'h00400, 16'h0000);
    cmp({16'h0, mem_rdata[15:0]}, 32'h5b5a, "half read");
    mem_acc(1'b0, 1'b1, 18'h00400, 16'h0000);
    cmp({31'h0, mem_err}, 32'h1, "word refused");
    unlock(`FCI_CMD_RESET);
    mem_acc(1'b1, 1'b0, 18'h00100, 16'h1234);
    repeat (4) @(posedge sys_clk);
    cmp(starts, 0, "refused writes");
    $display("test program_mode done");
    reg_acc(1'b1, RA, 8'ha0);
    for (int i = 0; i < 3; i++) begin
      issue(OPS[i]);
      wait_idle(1'b0);
      repeat (3) @(posedge sys_clk);
      rchk(RA, 8'ha0, "busy status");
      reg_acc(1'b1, RA, 8'h80);
      mem_acc(1'b0, 1'b0, 18'h00400, 16'h0000);
      cmp({24'h0, mem_rdata[7:0]}, 32'h48, "busy read");
      issue(FCI_OP_PROGRAM);
      wait_idle(1'b1);
      repeat (6) @(posedge sys_clk);
      cmp(starts, i + 1, "busy refusal");
      cmp({30'h0, last_cmd.op}, {30'h0, OPS[i]}, "operation");
      cmp({16'h0, last_cmd.data}, {16'h0, DAT[i]}, "command data");
      cmp({31'h0, done_irq}, 32'h1, "irq raised");
      rchk(RA, 8'hf0, "flag set");
      reg_acc(1'b1, RA, i == 2 ? 8'h60 : 8'ha0);
      repeat (3) @(posedge sys_clk);
      cmp({31'h0, done_irq}, 32'h0, "irq withdrawn");
      rchk(RA, i == 2 ? 8'h70 : 8'hb0, "after clear");
    end
    $display("test algorithm done");
    #1 prog_pin = 1;
    repeat (5) @(posedge sys_clk);
    cmp({30'h0, cpu_halt, pins_to_flash}, 32'h3, "programmer mode");
    rchk(RA, 8'h00, "register hidden");
    mem_acc(1'b0, 1'b1, 18'h00400, 16'h0000);
    cmp({31'h0, mem_ack}, 32'h0, "cpu halted");
    #1 prog_pin = 0;
    repeat (5) @(posedge sys_clk);
    #1 reset = 1;
    repeat (2) @(posedge sys_clk);
    #1 reset = 0;
    repeat (3) @(posedge sys_clk);
    rchk(RA, 8'h10, "second reset");
    $display("test programmer_and_reset done");
    complete_run();
  end
endmodule
